// >>> core/tap_pkg.sv
package tap_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int IR_W  = 3;                     // instruction register width
  localparam int ID_W  = 32;                    // identification register width
  localparam int BSR_W = 16;                    // boundary chain length, plain default

  // ****************************************
  // instruction codes
  // ****************************************
  localparam logic [IR_W-1:0] IR_EXTEST  = 3'h0;  // drive preloaded pattern
  localparam logic [IR_W-1:0] IR_IDCODE  = 3'h1;  // identification, default
  localparam logic [IR_W-1:0] IR_SAMPLEZ = 3'h2;  // sample, outputs high-z
  localparam logic [IR_W-1:0] IR_PRELOAD = 3'h4;  // sample and preload
  localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;  // one-bit path

  // ****************************************
  // capture and reset values
  // ****************************************
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;  // low two bits 01 for fault isolation
  localparam logic [IR_W-1:0] IR_RESET   = IR_IDCODE;
  localparam logic [ID_W-1:0] ID_CODE_DEF = 32'h0a5a_5001;  // arbitrary value
  localparam logic            BYP_CAPTURE = 1'b0;           // bypass bit on capture
  localparam logic            PIN_IDLE    = 1'b1;           // pulled-up pin level
  localparam int              TMS_RESET_EDGES = 5;          // tms-high edges to reset

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    ST_TLR, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } tap_state_t;

  typedef enum logic [1:0] {
    SEL_BYP, SEL_ID, SEL_BSR
  } dr_sel_t;

endpackage

// >>> core/word_buf2.sv
module word_buf2 #(
  parameter int W     = tap_pkg::BSR_W,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  // filling side
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  // draining side
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  import tap_pkg::*;

  // ****************************************
  // storage, entry 0 is always the head
  // ****************************************
  logic [W-1:0] mem_q [DEPTH];  // word slots
  logic [DEPTH-1:0] vld_q;      // slot occupied
  logic          pop;           // head leaves
  logic          push;          // new word enters
  logic          slot;          // index written by a push

  // full when the last slot holds a word
  assign in_ready_o  = ~vld_q[DEPTH-1];
  assign out_valid_o = vld_q[0];
  assign out_data_o  = mem_q[0];
  assign pop  = vld_q[0] & out_ready_i;
  assign push = in_valid_i & ~vld_q[DEPTH-1];
  // a pop moves slot 1 forward, so the free slot follows the count left behind
  assign slot = pop ? vld_q[1] : vld_q[0];

  // shift on pop, then place the new word behind what is left
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vld_q  <= '0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (ce_i) begin
      if (pop) begin
        mem_q[0] <= mem_q[1];
        vld_q[0] <= vld_q[1];
        vld_q[1] <= 1'b0;
      end
      if (push) begin
        mem_q[slot] <= in_data_i;
        vld_q[slot] <= 1'b1;
      end
    end
  end

endmodule

// >>> core/boundary_scan_tap_core.sv
// Operation
// - state machine and serial port follow 1149.1
// - controller, instruction, boundary, bypass, identification registers
// - tms sampled on each test clock rise
// - inputs on rising edge, outputs on falling
// - tdi enters msb of selected register
// - tdo shows lsb of selected register
// - tdo driven only in shift states
// - five tms-high rises force reset state
// - tap reset never disturbs memory operation
// - power-up reset leaves tdo high-impedance
// - exactly one register between tdi and tdo
// - three-bit instruction, shifted only on ir path
// - reset loads identification instruction
// - capture-ir loads 01 into low bits
// - tdi and tms idle high when open
// - new instruction acts only at update-ir
// - bypass is one bit, captures zero
// - identification captures fixed 32-bit code
module boundary_scan_tap_core #(
  parameter logic [31:0] ID_CODE = tap_pkg::ID_CODE_DEF  // arbitrary value
) (
  // clock, reset, enable
  input  wire logic                        core_clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        ce_i,
  // test port pins
  input  wire logic                        tck_i,
  input  wire logic                        tms_i,
  input  wire logic                        tdi_i,
  output logic                             tdo_o,
  output logic                             tdo_oe_o,
  // io ring snapshot, same clock
  input  wire logic [tap_pkg::BSR_W-1:0]   bsr_capture_i,
  // boundary update words toward the io ring
  output logic [tap_pkg::BSR_W-1:0]        upd_data_o,
  output logic                             upd_valid_o,
  input  wire logic                        upd_ready_i,
  // io ring control
  output logic                             extest_o,
  output logic                             highz_o
);
  import tap_pkg::*;

  // ****************************************
  // functions
  // ****************************************

  // standard sixteen-state walk, one step per test clock rise
  function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
    tap_state_t n;
    n = ST_TLR;
    case (s)
      ST_TLR:    n = tms ? ST_TLR    : ST_IDLE;
      ST_IDLE:   n = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  n = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: n = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: n = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: n = tms ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  n = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: n = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: n = tms ? ST_SEL_DR : ST_IDLE;
      default:   n = ST_TLR;
    endcase
    return n;
  endfunction

  // which data register the current instruction places on the path
  function automatic dr_sel_t dr_select(input logic [IR_W-1:0] ir);
    dr_sel_t d;
    d = SEL_BYP;
    case (ir)
      IR_EXTEST, IR_SAMPLEZ, IR_PRELOAD: d = SEL_BSR;
      IR_IDCODE:                         d = SEL_ID;
      default:                           d = SEL_BYP;
    endcase
    return d;
  endfunction

  // ****************************************
  // pin synchronisers and edge finding
  // ****************************************
  logic tck_s1_q, tck_s2_q, tck_prev_q;  // test clock samples
  logic tms_s1_q, tms_s2_q;              // mode select samples
  logic tdi_s1_q, tdi_s2_q;              // serial data samples
  logic tck_rise;                        // one-cycle rise marker
  logic tck_fall;                        // one-cycle fall marker

  // pins come from the scan controller's domain; tms and tdi idle at the pulled-up high, the test clock idles low
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tck_s1_q   <= 1'b0;
      tck_s2_q   <= 1'b0;
      tck_prev_q <= 1'b0;
      tms_s1_q   <= PIN_IDLE;
      tms_s2_q   <= PIN_IDLE;
      tdi_s1_q   <= PIN_IDLE;
      tdi_s2_q   <= PIN_IDLE;
    end else if (ce_i) begin
      tck_s1_q   <= tck_i;
      tck_s2_q   <= tck_s1_q;
      tck_prev_q <= tck_s2_q;
      tms_s1_q   <= tms_i;
      tms_s2_q   <= tms_s1_q;
      tdi_s1_q   <= tdi_i;
      tdi_s2_q   <= tdi_s1_q;
    end
  end

  // a test clock held low gives no edges, so the port stays parked
  assign tck_rise = tck_s2_q & ~tck_prev_q;
  assign tck_fall = ~tck_s2_q & tck_prev_q;

  // ****************************************
  // controller state
  // ****************************************
  tap_state_t state_q;   // current controller state
  tap_state_t state_d;   // state after this rise
  logic       step;      // a rise while enabled

  assign step    = tck_rise & ce_i;
  assign state_d = tap_next(state_q, tms_s2_q);

  // advance only on a test clock rise; nothing here reaches the memory path
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_TLR;
    end else if (step) begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // instruction register
  // ****************************************
  logic [IR_W-1:0] ir_sh_q;  // instruction shift stage
  logic [IR_W-1:0] ir_q;     // instruction in force
  dr_sel_t         sel;      // selected data register

  assign sel = dr_select(ir_q);

  // shift stage moves only on the ir path; the held code changes at update-ir
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ir_sh_q <= IR_CAPTURE;
      ir_q    <= IR_RESET;
    end else if (step) begin
      case (state_q)
        ST_CAP_IR: ir_sh_q <= IR_CAPTURE;
        ST_SH_IR:  ir_sh_q <= {tdi_s2_q, ir_sh_q[IR_W-1:1]};
        ST_UPD_IR: ir_q    <= ir_sh_q;
        default:   ir_sh_q <= ir_sh_q;
      endcase
      // entering reset wins over any update in the same rise
      if (state_d == ST_TLR) begin
        ir_q <= IR_RESET;
      end
    end
  end

  // ****************************************
  // data registers
  // ****************************************
  logic             byp_q;     // bypass bit
  logic [ID_W-1:0]  id_sh_q;   // identification shift stage
  logic [BSR_W-1:0] bsr_sh_q;  // boundary shift stage

  // capture then shift only the register that the instruction selects
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      byp_q    <= BYP_CAPTURE;
      id_sh_q  <= '0;
      bsr_sh_q <= '0;
    end else if (step) begin
      if (state_q == ST_CAP_DR) begin
        case (sel)
          SEL_ID:  id_sh_q  <= ID_CODE;
          SEL_BSR: bsr_sh_q <= bsr_capture_i;
          default: byp_q    <= BYP_CAPTURE;
        endcase
      end else if (state_q == ST_SH_DR) begin
        case (sel)
          SEL_ID:  id_sh_q  <= {tdi_s2_q, id_sh_q[ID_W-1:1]};
          SEL_BSR: bsr_sh_q <= {tdi_s2_q, bsr_sh_q[BSR_W-1:1]};
          default: byp_q    <= tdi_s2_q;
        endcase
      end
    end
  end

  // ****************************************
  // serial output, falling edge only
  // ****************************************
  logic tdo_q;     // data out
  logic tdo_oe_q;  // data out driven
  logic dr_lsb;    // lsb of the selected data register
  logic in_shift;  // shift state now

  always_comb begin
    case (sel)
      SEL_ID:  dr_lsb = id_sh_q[0];
      SEL_BSR: dr_lsb = bsr_sh_q[0];
      default: dr_lsb = byp_q;
    endcase
  end

  assign in_shift = (state_q == ST_SH_DR) | (state_q == ST_SH_IR);

  // output follows the state reached at the previous rise, half a cycle later
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall && ce_i) begin
      tdo_oe_q <= in_shift;
      if (state_q == ST_SH_IR) begin
        tdo_q <= ir_sh_q[0];
      end else begin
        tdo_q <= dr_lsb;
      end
    end
  end

  assign tdo_o    = tdo_q;
  assign tdo_oe_o = tdo_oe_q;

  // ****************************************
  // boundary update words and io ring control
  // ****************************************
  logic             pend_q;    // update word awaiting the buffer
  logic [BSR_W-1:0] pend_w_q;  // that word
  logic             buf_rdy;   // buffer can take a word
  logic             upd_ev;    // update-dr under a boundary load instruction
  logic             extest_q;  // extest in force
  logic             highz_q;   // sample-z in force

  assign upd_ev = step & (state_q == ST_UPD_DR) &
                  ((ir_q == IR_EXTEST) | (ir_q == IR_PRELOAD));

  // an update arriving while the old word is still refused is dropped:
  // the test clock cannot be stalled, so the buffer is the only slack
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_q   <= 1'b0;
      pend_w_q <= '0;
    end else if (ce_i) begin
      if (upd_ev && (!pend_q || buf_rdy)) begin
        pend_q   <= 1'b1;
        pend_w_q <= bsr_sh_q;
      end else if (buf_rdy) begin
        pend_q <= 1'b0;
      end
    end
  end

  word_buf2 #(
    .W     (BSR_W),
    .DEPTH (2)
  ) u_upd_buf (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .in_data_i   (pend_w_q),
    .in_valid_i  (pend_q),
    .in_ready_o  (buf_rdy),
    .out_data_o  (upd_data_o),
    .out_valid_o (upd_valid_o),
    .out_ready_i (upd_ready_i)
  );

  // io ring modes follow the instruction in force
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      extest_q <= 1'b0;
      highz_q  <= 1'b0;
    end else if (ce_i) begin
      extest_q <= (ir_q == IR_EXTEST);
      highz_q  <= (ir_q == IR_SAMPLEZ);
    end
  end

  assign extest_o = extest_q;
  assign highz_o  = highz_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  logic [2:0] tms_hi_q;  // consecutive tms-high rises, saturating

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tms_hi_q <= 3'h0;
    end else if (step) begin
      if (!tms_s2_q) begin
        tms_hi_q <= 3'h0;
      end else if (tms_hi_q != 3'(TMS_RESET_EDGES)) begin
        tms_hi_q <= tms_hi_q + 3'h1;
      end
    end
  end

  sequence s_rise_in(tap_state_t st);
    step && state_q == st;
  endsequence

  sequence s_fall;
    tck_fall && ce_i;
  endsequence

  chk_tms_five_reset: assert property (tms_hi_q == 3'(TMS_RESET_EDGES) |-> state_q == ST_TLR)
    else $error("five tms-high rises did not reach reset");
  chk_tdo_fall_only: assert property ($changed(tdo_q) |-> $past(tck_fall && ce_i))
    else $error("tdo changed away from a falling edge");
  chk_oe_shift_only: assert property (s_fall |=> tdo_oe_q == $past(in_shift))
    else $error("tdo enable does not follow shift state");
  chk_ir_capture_bits: assert property (s_rise_in(ST_CAP_IR) |=> ir_sh_q[1:0] == 2'b01)
    else $error("capture-ir pattern wrong");
  chk_ir_reset_code: assert property (state_q == ST_TLR |-> ir_q == IR_IDCODE)
    else $error("reset state without identification instruction");
  chk_ir_update_only: assert property ($changed(ir_q) |->
                                       $past(step && (state_q == ST_UPD_IR ||
                                                      state_d == ST_TLR)))
    else $error("instruction changed outside update-ir or reset");
  chk_id_capture_code: assert property (s_rise_in(ST_CAP_DR) ##0 sel == SEL_ID
                                        |=> id_sh_q == ID_CODE)
    else $error("identification capture wrong");
  chk_bypass_zero: assert property (s_rise_in(ST_CAP_DR) ##0 sel == SEL_BYP
                                    |=> byp_q == 1'b0)
    else $error("bypass did not capture zero");
  chk_reserved_bypass: assert property (ir_q inside {3'h3, 3'h5, 3'h6} |-> sel == SEL_BYP)
    else $error("reserved code not on bypass");
  chk_shift_msb_in: assert property (s_rise_in(ST_SH_DR) ##0 sel == SEL_ID |=>
                                     id_sh_q == {$past(tdi_s2_q), $past(id_sh_q[ID_W-1:1])})
    else $error("tdi did not enter the msb");
  chk_tdo_lsb_out: assert property (s_fall ##0 state_q == ST_SH_DR ##0 sel == SEL_BYP
                                    |=> tdo_q == $past(byp_q))
    else $error("tdo is not the selected lsb");

endmodule

// >>> verif/scan_host_model.sv
// ****************************************
// scan controller model on the test port
// ****************************************
module scan_host_model (
  // test port drive
  output logic      tck_o,
  output logic      tms_o,
  output logic      tms_oe_o,
  output logic      tdi_o,
  output logic      tdi_oe_o,
  // test port return
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;

  int oe_errs;  // enable seen outside, or missing inside, a shift state

  // test clock rests low between frames
  initial begin
    tck_o    = 1'b0;
    tms_o    = 1'b1;
    tms_oe_o = 1'b1;
    tdi_o    = 1'b1;
    tdi_oe_o = 1'b0;
    oe_errs  = 0;
  end

  // one 160 ns test clock; tms of z releases the pin to its pull-up
  // a call starts 1 ns after a core edge and every step is a multiple of 8 ns,
  // so no pin moves in the time step of a core clock edge
  // tdo is read 48 ns after the fall, once the output has settled
  task automatic clk1(input logic tms, input logic tdi, input logic drv,
                      input logic exp_oe, output logic tdo);
    tms_oe_o = (tms !== 1'bz);
    tms_o = tms;
    tdi_oe_o = drv;
    tdi_o = tdi;
    #32;
    tck_o = 1'b1;
    #80;
    tck_o = 1'b0;
    #48;
    tdo = tdo_i;
    if (tdo_oe_i !== exp_oe) begin
      oe_errs++;
    end
  endtask

  // five high rises on the released pin, then idle
  task automatic reset_to_idle();
    logic d;
    repeat (5) clk1(1'bz, 1'b1, 1'b0, 1'b0, d);
    clk1(1'b0, 1'b1, 1'b0, 1'b0, d);
  endtask

  // idle to exit1-ir, code sent lsb first, captured bits returned
  task automatic ir_shift(input logic [2:0] code, output logic [2:0] cap);
    logic d;
    clk1(1'b1, 1'b1, 1'b0, 1'b0, d);
    clk1(1'b1, 1'b1, 1'b0, 1'b0, d);
    clk1(1'b0, 1'b1, 1'b0, 1'b0, d);
    clk1(1'b0, 1'b1, 1'b0, 1'b1, d);
    cap[0] = d;
    for (int i = 0; i < 3; i++) begin
      clk1(i == 2, code[i], 1'b1, i != 2, d);
      if (i < 2) begin
        cap[i+1] = d;
      end
    end
  endtask

  // exit1-ir through update-ir back to idle
  task automatic ir_finish();
    logic d;
    clk1(1'b1, 1'b1, 1'b0, 1'b0, d);
    clk1(1'b0, 1'b1, 1'b0, 1'b0, d);
  endtask

  // idle, shift n bits of din, update, idle; dout holds what came out
  task automatic dr_scan(input int n, input logic [31:0] din,
                         output logic [31:0] dout);
    logic d;
    dout = '0;
    clk1(1'b1, 1'b1, 1'b0, 1'b0, d);
    clk1(1'b0, 1'b1, 1'b0, 1'b0, d);
    clk1(1'b0, 1'b1, 1'b0, 1'b1, d);
    dout[0] = d;
    for (int i = 0; i < n; i++) begin
      clk1(i == n - 1, din[i], 1'b1, i != n - 1, d);
      if (i < n - 1) begin
        dout[i+1] = d;
      end
    end
    clk1(1'b1, 1'b1, 1'b0, 1'b0, d);
    clk1(1'b0, 1'b1, 1'b0, 1'b0, d);
  endtask
endmodule

// >>> verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tap_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  localparam logic [31:0]    ID_VAL = 32'h1234_5a5b;  // arbitrary value
  localparam logic [BSR_W-1:0] RING = 16'hc3a5;        // ring snapshot
  logic              core_clk, rstn;
  logic              tck, tms_d, tms_oe, tdi_d, tdi_oe, tdo, tdo_oe;
  wire logic         tms_w, tdi_w;
  logic [BSR_W-1:0]  bsr_cap, upd_data;
  logic              upd_valid, upd_ready, extest, highz;
  logic [BSR_W-1:0]  got_q[$];  // words taken by the sink
  logic [31:0]       d;
  logic [2:0]        cap;
  int                err_count, n_compared, cyc;

  // released pins read high through the pad pull-ups
  assign tms_w = tms_oe ? tms_d : 1'b1;
  assign tdi_w = tdi_oe ? tdi_d : 1'b1;

  boundary_scan_tap_core #(.ID_CODE(ID_VAL)) dut (
    .core_clk_i(core_clk), .rstn_i(rstn), .ce_i(1'b1),
    .tck_i(tck), .tms_i(tms_w), .tdi_i(tdi_w), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .bsr_capture_i(bsr_cap), .upd_data_o(upd_data), .upd_valid_o(upd_valid),
    .upd_ready_i(upd_ready), .extest_o(extest), .highz_o(highz));

  scan_host_model host (
    .tck_o(tck), .tms_o(tms_d), .tms_oe_o(tms_oe), .tdi_o(tdi_d),
    .tdi_oe_o(tdi_oe), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  // ****************************************
  // clock, sink, watchdog
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // sink takes a word whenever valid and ready meet
  always @(posedge core_clk) begin
    if (rstn === 1'b1 && upd_valid === 1'b1 && upd_ready === 1'b1) begin
      got_q.push_back(upd_data);
    end
  end

  // the whole run needs under 8000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      give_verdict();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic load_ir(input logic [2:0] code);
    host.ir_shift(code, cap);
    host.ir_finish();
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power_up();
    check("tdo_oe at reset", 1'b0, tdo_oe);
    check("extest at reset", 1'b0, extest);
    check("upd_valid at reset", 1'b0, upd_valid);
    host.reset_to_idle();
    host.dr_scan(32, 32'h0, d);
    check("id read", ID_VAL, d);
    $display("power-up test done");
  endtask

  // bypass and every reserved code: one-bit path that captures zero
  task automatic t_bypass_codes();
    logic [2:0] codes [4];
    codes = '{IR_BYPASS, 3'h3, 3'h5, 3'h6};
    foreach (codes[i]) begin
      host.ir_shift(codes[i], cap);
      check("ir capture", IR_CAPTURE, cap);
      host.ir_finish();
      host.dr_scan(4, 32'ha, d);
      check("bypass path", {28'h0, 3'b010, BYP_CAPTURE}, d);
    end
    $display("bypass test done");
  endtask

  task automatic t_sample_highz();
    got_q.delete();
    host.ir_shift(IR_SAMPLEZ, cap);
    check("highz before update", 1'b0, highz);
    host.ir_finish();
    check("highz in force", 1'b1, highz);
    check("extest idle", 1'b0, extest);
    host.dr_scan(16, 32'h1234, d);
    check("ring capture", {16'h0, RING}, d);
    check("no word", 0, got_q.size());
    $display("sample test done");
  endtask

  // three words fill buffer and pending stage, a fourth is dropped
  task automatic t_preload_fill();
    logic [15:0] w [4];
    w = '{16'h0001, 16'h8000, 16'h5a5a, 16'hffff};
    got_q.delete();
    upd_ready = 1'b0;
    load_ir(IR_PRELOAD);
    check("highz dropped", 1'b0, highz);
    foreach (w[i]) begin
      host.dr_scan(16, {16'h0, w[i]}, d);
    end
    check("preload capture", {16'h0, RING}, d);
    check("stalled valid", 1'b1, upd_valid);
    check("stalled head", w[0], upd_data);
    @(posedge core_clk);
    #1 upd_ready = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    check("words drained", 3, got_q.size());
    for (int i = 0; i < 3 && i < got_q.size(); i++) begin
      check("word order", w[i], got_q[i]);
    end
    check("valid after drain", 1'b0, upd_valid);
    $display("buffer test done");
  endtask

  // tms-high escape from shift-dr, then a reset in mid-run
  task automatic t_extest_resets();
    load_ir(IR_EXTEST);
    check("extest in force", 1'b1, extest);
    host.clk1(1'b1, 1'b1, 1'b0, 1'b0, cap[0]);
    host.clk1(1'b0, 1'b1, 1'b0, 1'b0, cap[0]);
    host.clk1(1'b0, 1'b1, 1'b0, 1'b1, cap[0]);
    repeat (5) host.clk1(1'b1, 1'b1, 1'b0, 1'b0, cap[0]);
    check("extest after reset", 1'b0, extest);
    host.clk1(1'b0, 1'b1, 1'b0, 1'b0, cap[0]);
    host.dr_scan(32, 32'h0, d);
    check("id after tms reset", ID_VAL, d);
    load_ir(IR_BYPASS);
    // park in shift-dr with tdo driven, so the reset has an enable to drop
    host.clk1(1'b1, 1'b1, 1'b0, 1'b0, cap[0]);
    host.clk1(1'b0, 1'b1, 1'b0, 1'b0, cap[0]);
    host.clk1(1'b0, 1'b1, 1'b0, 1'b1, cap[0]);
    @(posedge core_clk);
    #1 rstn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rstn = 1'b1;
    check("tdo_oe after reset", 1'b0, tdo_oe);
    repeat (4) @(posedge core_clk);
    #1;
    host.clk1(1'b0, 1'b1, 1'b0, 1'b0, cap[0]);
    host.dr_scan(32, 32'h0, d);
    check("id after async reset", ID_VAL, d);
    $display("reset test done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    bsr_cap = RING;
    upd_ready = 1'b1;
    err_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (2) @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    t_power_up();
    t_bypass_codes();
    t_sample_highz();
    t_preload_fill();
    t_extest_resets();
    check("enable only in shift", 0, host.oe_errs);
    give_verdict();
  end
endmodule
